/* hdl/bts_sequencer.sv */
// Burst and trigger sequencer for one waveform generator channel.
`timescale 1ns/1ns
`include "bts_consts.svh"
module bts_sequencer import bts_pkg::*; #(
  parameter int unsigned PERIOD_DEF_CYC = `BTS_PERIOD_DEF_CYC
) (
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Shared trigger connector
  input wire logic ext_trig_in,
  output logic ext_trig_out,
  output logic ext_trig_oe,
  // Front panel trigger key
  input wire logic manual_trigger,
  output logic trigger_wait_lamp,
  // Waveform engine
  input wire logic wave_cycle_end,
  output logic wave_run,
  output logic wave_noise_stop,
  output logic phase_load,
  output logic [15:0] phase_value,
  output logic [15:0] duty_value,
  output logic list_advance,
  output logic [7:0] list_index
);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  bts_state_s r;
  bts_state_s n;

  logic acc;
  logic wr;
  logic mapped;
  bts_src_e src;
  logic gate_true;
  logic ext_edge;
  logic start;
  logic trig;
  logic bus_cmd;
  logic man_cmd;
  logic [39:0] need;
  logic [39:0] eff_period;
  logic burst_done;

  assign acc = psel & penable;
  assign wr = acc & pwrite;
  assign pready = 1'b1;
  assign mapped = (paddr <= `BTS_LIST_OFS) && (paddr[1:0] == 2'b00);
  assign pslverr = acc & ~mapped;
  assign prdata = r.prdata;
  assign src = bts_src_e'(r.ctrl[`BTS_F_SRC_LO +: 2]);
  assign gate_true = ext_trig_in ^ r.ctrl[`BTS_F_GATE_LOW]; // [R10]
  // Edge of chosen slope on the connector
  assign ext_edge = r.ctrl[`BTS_F_TRIG_FALL] ? (r.gate_prev & ~ext_trig_in)
                                             : (~r.gate_prev & ext_trig_in);
  assign bus_cmd = wr && paddr == `BTS_CMD_OFS && pwdata[`BTS_F_CMD_BUS];
  assign man_cmd = manual_trigger | (wr && paddr == `BTS_CMD_OFS && pwdata[`BTS_F_CMD_MAN]);
  // Shortest legal repeat period: count times cycle length plus margin
  assign need = 40'(r.count) * 40'(r.cycle) + 40'(`BTS_MARGIN_CYC); // [R12]
  assign eff_period = (r.period < need) ? need : r.period; // [R13]
  assign burst_done = wave_cycle_end && r.cyc_left == 32'h1 && !r.ctrl[`BTS_F_INFINITE];

  // ----------------------------------------------------------------
  // Trigger selection
  // ----------------------------------------------------------------
  always_comb begin
    trig = 1'b0;
    unique case (src)
      BTS_SRC_IMM: trig = (r.state == BTS_IDLE) || (r.per_cnt == 40'h1); // [R16]
      BTS_SRC_EXT: trig = ext_edge & (r.state != BTS_RUN); // [R18] [R19]
      BTS_SRC_TIMER: trig = (r.ctrl[`BTS_F_INIT] & ~r.init_seen) || (r.tmr_cnt == 40'h1); // [R21]
      BTS_SRC_BUS: trig = bus_cmd | man_cmd; // [R20] [R4]
    endcase
    if (!r.ctrl[`BTS_F_BURST] && !r.ctrl[`BTS_F_LIST]) begin
      trig = 1'b0;
    end
  end
  // Gated mode drops all triggers, manual included, without error
  assign start = trig & ~r.ctrl[`BTS_F_GATED] & r.ctrl[`BTS_F_BURST]; // [R9]

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb begin
    n = r;
    n.gate_prev = ext_trig_in;
    n.gate_true_d = gate_true;
    n.load_phase = 1'b0;
    if (psel && !penable && !pwrite) begin
      unique case (paddr)
        `BTS_CTRL_OFS: n.prdata = {17'h0, r.ctrl};
        `BTS_COUNT_OFS: n.prdata = r.count;
        `BTS_PERIOD_OFS: n.prdata = r.period[31:0];
        `BTS_PHASE_OFS: n.prdata = {16'h0, r.phase};
        `BTS_DWELL_OFS: n.prdata = r.dwell;
        `BTS_CYCLE_OFS: n.prdata = r.cycle;
        `BTS_TIMER_OFS: n.prdata = r.timer[31:0];
        `BTS_DUTY_OFS: n.prdata = {r.duty_act, r.duty};
        `BTS_STATUS_OFS: n.prdata = {r.cyc_left[23:0], 6'h0, r.state};
        `BTS_LIST_OFS: n.prdata = {16'h0, r.list_len, r.list_idx};
        default: n.prdata = 32'h0;
      endcase
    end
    if (wr) begin
      unique case (paddr)
        `BTS_CTRL_OFS: begin
          n.ctrl = pwdata[14:0];
          // Later enable wins; burst takes precedence if both set at once
          if (pwdata[`BTS_F_BURST]) begin
            n.ctrl[`BTS_F_SWEEP] = 1'b0; // [R6]
            n.ctrl[`BTS_F_LIST] = 1'b0;
            n.ctrl[`BTS_F_MOD] = 1'b0;
          end else if (pwdata[`BTS_F_SWEEP] | pwdata[`BTS_F_LIST]) begin
            n.ctrl[`BTS_F_MOD] = 1'b0; // [R6]
          end
          if (bts_src_e'(pwdata[`BTS_F_SRC_LO +: 2]) == BTS_SRC_EXT) begin
            n.ctrl[`BTS_F_TOUT_EN] = 1'b0; // [R3]
          end
          if (!pwdata[`BTS_F_INIT]) begin
            n.init_seen = 1'b0;
          end
        end
        // Count kept whatever the mode, clamped to its legal range
        `BTS_COUNT_OFS: n.count = (pwdata == 32'h0) ? 32'h1 :
            (pwdata > `BTS_COUNT_MAX) ? `BTS_COUNT_MAX : pwdata; // [R11] [R14]
        `BTS_PERIOD_OFS: n.period = (pwdata < `BTS_PERIOD_MIN_CYC) ?
            40'(`BTS_PERIOD_MIN_CYC) : 40'(pwdata); // [R15]
        `BTS_PHASE_OFS: n.phase = pwdata[15:0]; // [R17]
        `BTS_DWELL_OFS: n.dwell = (pwdata == 32'h0) ? 32'h1 : pwdata;
        `BTS_CYCLE_OFS: n.cycle = (pwdata == 32'h0) ? 32'h1 : pwdata;
        `BTS_TIMER_OFS: n.timer = (pwdata == 32'h0) ? 40'h1 : 40'(pwdata);
        `BTS_DUTY_OFS: begin
          n.duty = pwdata[15:0];
          if (src == BTS_SRC_TIMER && r.state != BTS_IDLE) begin
            n.duty_pend = pwdata[15:0]; // [R22]
            n.duty_wait = 2'h2;
          end else begin
            n.duty_act = pwdata[15:0];
            n.duty_wait = 2'h0;
          end
        end
        `BTS_LIST_OFS: n.list_len = pwdata[15:8];
        default: ;
      endcase
    end
    // Timer: first trigger at init, then every timer period
    if (src == BTS_SRC_TIMER && r.ctrl[`BTS_F_INIT]) begin
      if (!r.init_seen || r.tmr_cnt == 40'h1) begin
        n.init_seen = 1'b1;
        n.tmr_cnt = r.timer; // [R21]
      end else begin
        n.tmr_cnt = r.tmr_cnt - 40'h1;
      end
    end
    // List stepping by dwell or trigger spacing
    if (r.ctrl[`BTS_F_LIST]) begin
      if (src == BTS_SRC_IMM) begin
        n.dwl_cnt = (r.dwl_cnt <= 32'h1) ? r.dwell : r.dwl_cnt - 32'h1; // [R5]
      end
      if ((src == BTS_SRC_IMM && r.dwl_cnt == 32'h1) || (src != BTS_SRC_IMM && trig)) begin
        n.list_idx = (r.list_idx >= r.list_len) ? 8'h0 : r.list_idx + 8'h1; // [R23]
      end
    end
    // Repeat period counter for immediate source
    if (r.per_cnt != 40'h0) begin
      n.per_cnt = r.per_cnt - 40'h1;
    end
    // Burst engine
    unique case (r.state)
      BTS_IDLE: begin
        if (r.ctrl[`BTS_F_BURST] && r.ctrl[`BTS_F_GATED] && gate_true) begin
          n.state = BTS_RUN; // [R8]
          n.load_phase = 1'b1; // [R24]
        end
      end
      BTS_RUN: begin
        if (r.ctrl[`BTS_F_GATED]) begin
          if (!gate_true && (wave_cycle_end || r.ctrl[`BTS_F_NOISE])) begin
            n.state = BTS_IDLE; // [R8]
          end
        end else if (burst_done) begin
          n.state = (src == BTS_SRC_IMM) ? BTS_GAP : BTS_IDLE; // [R7]
          if (r.duty_wait != 2'h0) begin
            n.duty_wait = r.duty_wait - 2'h1;
            if (r.duty_wait == 2'h1) begin
              n.duty_act = r.duty_pend; // [R22]
            end
          end
        end else if (wave_cycle_end) begin
          n.cyc_left = r.cyc_left - 32'h1;
        end
      end
      BTS_GAP: ;
      default: n.state = BTS_IDLE;
    endcase
    if (!r.ctrl[`BTS_F_BURST]) begin
      n.state = BTS_IDLE;
    end else if (start && (r.state != BTS_RUN || src == BTS_SRC_IMM)) begin
      n.state = BTS_RUN;
      n.cyc_left = r.count; // [R7]
      n.load_phase = 1'b1; // [R24]
      if (src == BTS_SRC_IMM) begin
        n.per_cnt = eff_period;
      end
    end
    // Trigger out generation
    if (start && r.ctrl[`BTS_F_TOUT_EN]) begin
      if (src == BTS_SRC_IMM || src == BTS_SRC_TIMER) begin
        n.sq_half = ((src == BTS_SRC_IMM) ? eff_period : r.timer) >> 1; // [R2]
        n.sq_cnt = ((src == BTS_SRC_IMM) ? eff_period : r.timer) >> 1;
        n.tout = 1'b1;
      end else begin
        n.tp_cnt = 16'(`BTS_PULSE_CYC); // [R4]
        n.tout = 1'b1;
      end
    end else if (r.tp_cnt != 16'h0) begin
      n.tp_cnt = r.tp_cnt - 16'h1;
      if (r.tp_cnt == 16'h1) begin
        n.tout = 1'b0;
      end
    end else if (r.sq_cnt > 40'h1) begin
      n.sq_cnt = r.sq_cnt - 40'h1;
    end else if (r.sq_cnt == 40'h1) begin
      n.sq_cnt = 40'h0;
      n.tout = 1'b0;
    end
    if (!r.ctrl[`BTS_F_TOUT_EN]) begin
      n.tout = 1'b0;
      n.tp_cnt = 16'h0;
      n.sq_cnt = 40'h0;
    end
    n.phase_out = r.phase;
  end

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r <= '0;
      r.count <= 32'h1;
      r.period <= 40'(PERIOD_DEF_CYC); // [R15]
      r.dwell <= 32'h1;
      r.cycle <= 32'h1;
      r.timer <= 40'h1;
      r.duty <= 16'h8000;
      r.duty_act <= 16'h8000;
      r.state <= BTS_IDLE;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  // Selected slope inverts the idle level too
  assign ext_trig_out = r.tout ^ r.ctrl[`BTS_F_TOUT_FALL]; // [R1]
  assign ext_trig_oe = r.ctrl[`BTS_F_TOUT_EN] && src != BTS_SRC_EXT; // [R3]
  assign trigger_wait_lamp = r.ctrl[`BTS_F_BURST] && src == BTS_SRC_BUS &&
                             r.state == BTS_IDLE && !r.ctrl[`BTS_F_GATED]; // [R20]
  assign wave_run = (r.state == BTS_RUN);
  assign wave_noise_stop = r.ctrl[`BTS_F_NOISE] & r.ctrl[`BTS_F_GATED] & ~gate_true; // [R8]
  assign phase_load = r.load_phase;
  assign phase_value = r.phase_out;
  assign duty_value = r.duty_act;
  assign list_advance = (r.list_idx != n.list_idx);
  assign list_index = r.list_idx;

endmodule : bts_sequencer

/* inc/bts_consts.svh */
// Constants of the burst trigger sequencer: offsets, fields, resets, timing.
// Function
// [R1] Enabled trigger out gives selected edge at each burst or sweep start; code gives it at triggered burst starts only, not at gated ones.
// [R2] Immediate source: trigger out is 50% square over the repeat period.
// [R3] External source selected: trigger out disabled, connector is input.
// [R4] Manual or bus source: one fixed-width pulse per burst start.
// [R5] List mode: dwell timer with immediate source, else trigger spacing.
// [R6] Burst, sweep/list and modulation exclude each other.
// [R7] Triggered burst emits exactly the cycle count, then waits.
// [R8] Gated burst runs while gate true, finishes cycle; noise stops at once.
// [R9] Gated burst ignores count, period, source and manual triggers silently.
// [R10] Gate polarity normal (high true, default) or gate_active_low.
// [R11] Cycle count 1 to 100,000,000 or infinite, triggered mode only.
// [R12] Immediate repeat period must exceed count/frequency plus a margin.
// [R13] Too short a repeat period is lengthened, frequency untouched.
// [R14] Count written in gated mode is kept for triggered mode.
// [R15] Repeat period 1 us to 8000 s, default 10 ms; code takes a 32-bit count of 4 ns clocks, so about 17 s at most.
// [R16] Repeat period used only with the immediate source.
// [R17] Start phase -360 to +360 degrees, default 0.
// [R18] External source: each selected-polarity edge starts one burst.
// [R19] External edges during a burst are ignored.
// [R20] Bus command starts one burst; waiting indicator lit meanwhile.
// [R21] Timer source triggers at fixed spacing, first one at once; code triggers only while BTS_F_INIT is set.
// [R22] Duty change under timer bursts applies after one more burst.
// [R23] In list mode each accepted trigger advances the list.
// [R24] Each burst start loads the phase generator with the start phase.
`ifndef BTS_CONSTS_SVH
`define BTS_CONSTS_SVH

`define BTS_CTRL_OFS 12'h000
`define BTS_COUNT_OFS 12'h004
`define BTS_PERIOD_OFS 12'h008
`define BTS_PHASE_OFS 12'h00C
`define BTS_DWELL_OFS 12'h010
`define BTS_CYCLE_OFS 12'h014
`define BTS_TIMER_OFS 12'h018
`define BTS_DUTY_OFS 12'h01C
`define BTS_CMD_OFS 12'h020
`define BTS_STATUS_OFS 12'h024
`define BTS_LIST_OFS 12'h028

// Control and command fields
`define BTS_F_BURST 0
`define BTS_F_SWEEP 1
`define BTS_F_MOD 2
`define BTS_F_LIST 3
`define BTS_F_GATED 4
`define BTS_F_SRC_LO 5
`define BTS_F_TRIG_FALL 8
`define BTS_F_TOUT_EN 9
`define BTS_F_TOUT_FALL 10
`define BTS_F_GATE_LOW 11
`define BTS_F_NOISE 12
`define BTS_F_INFINITE 13
`define BTS_F_INIT 14
`define BTS_F_CMD_BUS 0
`define BTS_F_CMD_MAN 1

`define BTS_COUNT_MAX 32'h05F5E100
`define BTS_PERIOD_MIN_NS 1000
`define BTS_PERIOD_DEF_NS 10000000
`define BTS_MARGIN_NS 1000
`define BTS_PULSE_NS 1100
`define BTS_CLK_NS 4
`define BTS_PERIOD_DEF_CYC (`BTS_PERIOD_DEF_NS / `BTS_CLK_NS)
`define BTS_PERIOD_MIN_CYC ((`BTS_PERIOD_MIN_NS + `BTS_CLK_NS - 1) / `BTS_CLK_NS)
`define BTS_MARGIN_CYC ((`BTS_MARGIN_NS + `BTS_CLK_NS - 1) / `BTS_CLK_NS)
`define BTS_PULSE_CYC ((`BTS_PULSE_NS + `BTS_CLK_NS - 1) / `BTS_CLK_NS)

`endif

/* inc/bts_pkg.sv */
// Types of the burst trigger sequencer.
package bts_pkg;

  typedef enum logic [1:0] {
    BTS_SRC_IMM,
    BTS_SRC_EXT,
    BTS_SRC_TIMER,
    BTS_SRC_BUS
  } bts_src_e;

  typedef enum logic [1:0] {
    BTS_IDLE,
    BTS_RUN,
    BTS_GAP
  } bts_state_e;

  typedef struct packed {
    logic [14:0] ctrl;
    logic [31:0] count;
    logic [39:0] period;
    logic [15:0] phase;
    logic [31:0] dwell;
    logic [31:0] cycle;
    logic [39:0] timer;
    logic [15:0] duty;
    logic [15:0] duty_act;
    logic [15:0] duty_pend;
    logic [1:0] duty_wait;
    bts_state_e state;
    logic [31:0] cyc_left;
    logic [31:0] cyc_tick;
    logic [39:0] per_cnt;
    logic [39:0] tmr_cnt;
    logic [31:0] dwl_cnt;
    logic [15:0] tp_cnt;
    logic [39:0] sq_cnt;
    logic [39:0] sq_half;
    logic tout;
    logic gate_prev;
    logic gate_true_d;
    logic [7:0] list_idx;
    logic [7:0] list_len;
    logic load_phase;
    logic [15:0] phase_out;
    logic [31:0] prdata;
    logic init_seen;
  } bts_state_s;

endpackage : bts_pkg

/* verif/bts_chk.sv */
// Port checker of the burst trigger sequencer, bound to its top module.
`timescale 1ns/1ns
`include "bts_consts.svh"
module bts_chk (
  // Clock, reset and APB
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic pready,
  input wire logic pslverr,
  // Connector and engine
  input wire logic ext_trig_in,
  input wire logic ext_trig_out,
  input wire logic ext_trig_oe,
  input wire logic trigger_wait_lamp,
  input wire logic wave_run,
  input wire logic phase_load,
  input wire logic [15:0] phase_value
);
  // ----
  // Shadow of the setup
  // ----
  logic [14:0] sh_ctrl;
  logic [15:0] sh_phase;
  logic [1:0] age;
  logic [8:0] hi_cnt;
  logic wr_acc;
  logic settled;
  logic [1:0] src;
  assign wr_acc = psel && penable && pwrite && pready;
  assign settled = age == 2'h3;
  assign src = sh_ctrl[6:5];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sh_ctrl <= '0;
      sh_phase <= '0;
      age <= '0;
      hi_cnt <= '0;
    end else begin
      if (wr_acc && paddr == `BTS_CTRL_OFS) begin
        sh_ctrl <= pwdata[14:0];
      end
      if (wr_acc && paddr == `BTS_PHASE_OFS) begin
        sh_phase <= pwdata[15:0];
      end
      // Outputs may lag a write, so checks wait for it to settle
      age <= wr_acc ? 2'h0 : (settled ? age : age + 2'h1);
      hi_cnt <= ext_trig_out ? hi_cnt + 9'h001 : 9'h000;
    end
  end
  // ----
  // Assertions
  // ----
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_idle_ext;
    settled && src == 2'h1 && sh_ctrl[0] && !sh_ctrl[4] && !sh_ctrl[8] && !wave_run;
  endsequence
  sequence s_ext_rise;
    s_idle_ext ##1 $rose(ext_trig_in);
  endsequence
  AST_READY: assert property (psel && penable |-> pready)
    else $error("access without ready");
  AST_SLVERR: assert property (psel && penable && (paddr[1:0] != 2'h0 ||
    paddr > `BTS_LIST_OFS) |-> pslverr) else $error("unmapped access accepted");
  AST_EXT_NO_DRIVE: assert property (settled && src == 2'h1 |-> !ext_trig_oe)
    else $error("connector driven under external source");
  AST_OUT_DRIVE: assert property (settled && sh_ctrl[9] && src != 2'h1 |-> ext_trig_oe)
    else $error("trigger out not driven");
  AST_LAMP_BUS: assert property (settled && trigger_wait_lamp |-> src == 2'h3)
    else $error("wait lamp without bus source");
  AST_PHASE: assert property (settled && phase_load |-> phase_value == sh_phase)
    else $error("wrong start phase loaded");
  AST_LOAD_PULSE: assert property (phase_load |=> !phase_load)
    else $error("phase load longer than one cycle");
  AST_PULSE_WIDTH: assert property (settled && src == 2'h3 && !sh_ctrl[10] &&
    $fell(ext_trig_out) |-> hi_cnt == 9'(`BTS_PULSE_CYC)) else $error("bad pulse width");
  AST_EXT_START: assert property (s_ext_rise |-> ##[1:8] phase_load)
    else $error("external edge did not start a burst");
  AST_EXT_IGNORE: assert property (settled && src == 2'h1 && wave_run &&
    $rose(ext_trig_in) |=> (!phase_load) [*4]) else $error("edge in burst restarted");
endmodule : bts_chk

bind bts_sequencer bts_chk bts_chk_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
  .pwdata, .pready, .pslverr, .ext_trig_in, .ext_trig_out, .ext_trig_oe,
  .trigger_wait_lamp, .wave_run, .phase_load, .phase_value);

/* verif/bts_trig_src.sv */
// Outside equipment model driving the shared trigger connector.
`timescale 1ns/1ns
module bts_trig_src (
  // Clock
  input wire logic pclk,
  // Connector
  input wire logic ext_trig_oe,
  output logic src_level,
  output logic src_en
);
  initial begin
    src_level = 1'b0;
  end
  // Backs off while the device drives, avoiding contention
  always @(posedge pclk) src_en <= !ext_trig_oe;
  task automatic drive(input logic lvl, input int hold);
    @(posedge pclk);
    src_level <= lvl;
    repeat (hold) @(posedge pclk);
  endtask : drive
  task automatic edge_pulse(input logic rise, input int width);
    drive(!rise, 2);
    drive(rise, width);
    drive(!rise, 2);
  endtask : edge_pulse
endmodule : bts_trig_src

/* verif/tb.sv */
// Bench of the burst trigger sequencer over APB and the connector.
`timescale 1ns/1ns
`include "bts_consts.svh"
module tb;
  // ----
  // Signals
  // ----
  logic pclk;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic manual_trigger = 1'b0;
  logic wave_cycle_end = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata, rd_q;
  logic pready, pslverr, err_q, ext_trig_out, ext_trig_oe, trigger_wait_lamp, line;
  logic wave_run, wave_noise_stop, phase_load, list_advance, src_level, src_en;
  logic [15:0] phase_value, duty_value;
  logic [7:0] list_index;
  logic [1:0] div = 2'h0;
  int bad_count = 0;
  int tests_run = 0;
  int ends = 0, loads = 0, highs = 0, advs = 0, e0, l0, h0, e1, l1, h1;
  // Undriven connector is pulled low
  assign line = ext_trig_oe ? ext_trig_out : (src_en && src_level);
  bts_sequencer #(.PERIOD_DEF_CYC(50)) bts_sequencer_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .ext_trig_in(line), .ext_trig_out,
    .ext_trig_oe, .manual_trigger, .trigger_wait_lamp, .wave_cycle_end, .wave_run,
    .wave_noise_stop, .phase_load, .phase_value, .duty_value, .list_advance, .list_index);
  bts_trig_src bts_trig_src_i (.pclk, .ext_trig_oe, .src_level, .src_en);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // Engine stand-in: one waveform cycle every four clocks
  always @(posedge pclk) begin
    div <= wave_run ? div + 2'h1 : 2'h0;
    wave_cycle_end <= wave_run && div == 2'h2;
    ends <= ends + int'(wave_cycle_end && wave_run);
    loads <= loads + int'(phase_load);
    highs <= highs + int'(ext_trig_out);
    advs <= advs + int'(list_advance);
  end
  // ----
  // Tasks
  // ----
  task automatic check(input string what, input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    check("pready", pready, 32'h1);
    // Response and read word taken at the edge that sees pready high
    err_q = pslverr;
    rd_q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic rdc(input logic [11:0] a, input logic [31:0] exp, input string what);
    apb(1'b0, a, 32'h0);
    check(what, rd_q, exp);
  endtask : rdc
  task automatic wait_lvl(ref logic s, input logic v, input int lim, input string what);
    int n;
    n = 0;
    while (s !== v && n < lim) begin
      @(posedge pclk);
      n++;
    end
    check(what, s, v);
  endtask : wait_lvl
  task automatic snap(output int e, output int l, output int h);
    @(negedge pclk);
    e = ends;
    l = loads;
    h = highs;
    @(posedge pclk);
  endtask : snap
  task automatic kick();
    manual_trigger <= 1'b1;
    @(posedge pclk);
    manual_trigger <= 1'b0;
    @(posedge pclk);
  endtask : kick
  task automatic finish_test();
    if (bad_count == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask : finish_test
  // ----
  // Tests
  // ----
  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    check("duty reset", duty_value, 32'h8000);
    rdc(`BTS_PERIOD_OFS, 32'h32, "period reset");
    apb(1'b0, 12'h02C, 32'h0);
    check("unmapped err", err_q, 32'h1);
    check("unmapped data", rd_q, 32'h0);
    wr(`BTS_CTRL_OFS, 32'h64);
    wr(`BTS_CTRL_OFS, 32'h65);
    rdc(`BTS_CTRL_OFS, 32'h61, "burst over mod");
    wr(`BTS_CTRL_OFS, 32'h63);
    rdc(`BTS_CTRL_OFS, 32'h61, "burst over sweep");
    wr(`BTS_COUNT_OFS, 32'h3);
    wr(`BTS_PHASE_OFS, 32'h1234);
    wr(`BTS_CYCLE_OFS, 32'h4);
    wr(`BTS_CTRL_OFS, 32'h261);
    wait_lvl(trigger_wait_lamp, 1'b1, 20, "bus lamp");
    check("bus oe", ext_trig_oe, 32'h1);
    snap(e0, l0, h0);
    wr(`BTS_CMD_OFS, 32'h1);
    wait_lvl(wave_run, 1'b1, 20, "bus run");
    wait_lvl(wave_run, 1'b0, 60, "bus end");
    repeat (300) @(posedge pclk);
    snap(e1, l1, h1);
    check("bus cycles", e1 - e0, 32'h3);
    check("bus pulse", h1 - h0, 32'h113);
    wr(`BTS_COUNT_OFS, 32'h6);
    for (int p = 0; p < 2; p++) begin
      wr(`BTS_CTRL_OFS, 32'h221 | (p << 8));
      repeat (3) @(posedge pclk);
      check("ext oe", ext_trig_oe, 32'h0);
      snap(e0, l0, h0);
      bts_trig_src_i.edge_pulse(p == 0, 3);
      bts_trig_src_i.edge_pulse(p == 0, 2);
      wait_lvl(wave_run, 1'b0, 60, "ext end");
      snap(e1, l1, h1);
      check("ext bursts", l1 - l0, 32'h1);
      check("ext cycles", e1 - e0, 32'h6);
    end
    wr(`BTS_CTRL_OFS, 32'h831);
    wr(`BTS_COUNT_OFS, 32'h5);
    kick();
    repeat (10) @(posedge pclk);
    check("gated key", wave_run, 32'h0);
    bts_trig_src_i.drive(1'b0, 40);
    check("gate open", wave_run, 32'h1);
    bts_trig_src_i.drive(1'b1, 1);
    wait_lvl(wave_run, 1'b0, 10, "gate close");
    wr(`BTS_CTRL_OFS, 32'h1831);
    wait_lvl(wave_noise_stop, 1'b1, 8, "noise stop");
    wr(`BTS_CTRL_OFS, 32'h61);
    snap(e0, l0, h0);
    kick();
    wait_lvl(wave_run, 1'b1, 20, "key run");
    wait_lvl(wave_run, 1'b0, 60, "key end");
    snap(e1, l1, h1);
    check("kept count", e1 - e0, 32'h5);
    wr(`BTS_PERIOD_OFS, 32'h190);
    wr(`BTS_COUNT_OFS, 32'h2);
    wr(`BTS_CTRL_OFS, 32'h201);
    wait_lvl(phase_load, 1'b1, 500, "imm start");
    snap(e0, l0, h0);
    repeat (1599) @(posedge pclk);
    snap(e1, l1, h1);
    check("imm bursts", l1 - l0, 32'h4);
    check("imm square", h1 - h0, 32'h320);
    // Need is 64 cycles of 4 clocks plus margin, far above the clamped period
    wr(`BTS_COUNT_OFS, 32'h40);
    wr(`BTS_PERIOD_OFS, 32'h3C);
    wait_lvl(phase_load, 1'b1, 600, "imm restart");
    snap(e0, l0, h0);
    repeat (1599) @(posedge pclk);
    snap(e1, l1, h1);
    check("stretched", l1 - l0, 32'h3);
    // Stop the running burst so the first timer trigger is not swallowed
    wr(`BTS_CTRL_OFS, 32'h0);
    wr(`BTS_TIMER_OFS, 32'h3E8);
    wr(`BTS_CTRL_OFS, 32'h4041);
    wait_lvl(phase_load, 1'b1, 20, "timer first");
    snap(e0, l0, h0);
    repeat (1099) @(posedge pclk);
    snap(e1, l1, h1);
    check("timer spacing", l1 - l0, 32'h1);
    wr(`BTS_LIST_OFS, 32'h200);
    wr(`BTS_CTRL_OFS, 32'h68);
    wr(`BTS_CMD_OFS, 32'h1);
    rdc(`BTS_LIST_OFS, 32'h201, "list step");
    wr(`BTS_CMD_OFS, 32'h1);
    wr(`BTS_CMD_OFS, 32'h1);
    check("list wrap", list_index, 32'h0);
    check("list moves", advs, 32'h3);
    finish_test();
  end
  initial begin
    repeat (30000) @(posedge pclk);
    bad_count++;
    finish_test();
  end
endmodule : tb
